// File: logic/tct_pkg.sv
// Constants, types and register map of the timer capture and trigger control block.
// Assumes a 12-bit APB byte address, 32-bit data, and six counter channels.
package tct_pkg;

  // ==========================================================================
  // Register offsets
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_CLK_CTRL = 12'h080;
  localparam logic [11:0] OFF_CAP_FILT = 12'h090;
  localparam logic [11:0] OFF_DMA_EN = 12'h0a0;
  localparam logic [11:0] OFF_DMA_ROUTE = 12'h0a4;
  localparam logic [11:0] OFF_ADCT_CTRL = 12'h0d0;
  localparam logic [11:0] OFF_ADCT_DLY = 12'h0d8;
  localparam logic [11:0] OFF_USER_REQ = 12'h0f0;

  // ==========================================================================
  // Field positions
  localparam int CLK_SRC_BIT = 0;
  localparam int GLITCH_LSB = 0;
  localparam int DIVIDER_LSB = 4;
  localparam int ROUTE0_LSB = 0;
  localparam int ROUTE1_LSB = 4;
  localparam int ADCT_EN_BIT = 8;
  localparam int ADCT_SEL_LSB = 0;
  localparam int RESTART_LSB = 8;
  localparam int RELOAD_LSB = 16;
  localparam int NUM_CH = 6;
  localparam int NUM_DMA = 2;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] RST_REG = 32'h0000_0000;

  // ==========================================================================
  // Channel function codes
  localparam logic [2:0] MODE_NONE = 3'h0;
  localparam logic [2:0] MODE_CAPTURE = 3'h1;
  localparam logic [2:0] MODE_SHOT_PULSE = 3'h4;
  localparam logic [2:0] MODE_SHOT_EDGE = 3'h5;
  localparam logic [2:0] MODE_PWM_EDGE = 3'h6;
  localparam logic [2:0] MODE_PWM_CENTER = 3'h7;
  localparam logic [2:0] LAST_CHANNEL = 3'h5;

  // ==========================================================================
  // Timing: the effective trigger delay is the delay register times four.
  localparam int ADC_DLY_SHIFT = 2;
  localparam int DIV_CNT_W = 7;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tct_apb_req_s;

  typedef enum logic {
    ADC_IDLE = 1'b0,
    ADC_WAIT = 1'b1
  } tct_adc_state_e;

endpackage

// File: logic/tct_capture_filter.sv
// Input capture trigger filter for one channel.
// Assumes the raw trigger is already synchronous to clk, which is the sampling clock.
`timescale 1ns/100ps
module tct_capture_filter (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Settings
  input wire logic [2:0] divider,
  input wire logic [2:0] glitch_width,
  // Trigger
  input wire logic trig_in,
  output logic level_q,
  output logic edge_q
);

  // ==========================================================================
  // Sampling divider and run-length filter
  logic [tct_pkg::DIV_CNT_W-1:0] pre_q, pre_d, mask;
  logic [2:0] run_q, run_d;
  logic level_d, edge_d, tick;

  always_comb begin
    // Sampling rate is clk divided by two to the divider value.  see RULE2
    mask = tct_pkg::DIV_CNT_W'((8'h01 << divider) - 8'h01);
    tick = ((pre_q & mask) == '0);
    pre_d = pre_q + 1'b1;
    run_d = run_q;
    level_d = level_q;
    edge_d = 1'b0;
    if (tick) begin
      if (trig_in == level_q) begin
        run_d = 3'h0;
      // A change is accepted after width+1 agreeing samples; code 7 acts as 8.  see RULE3
      end else if (run_q == glitch_width) begin
        level_d = trig_in;
        edge_d = 1'b1;
        run_d = 3'h0;
      end else begin
        run_d = run_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre_q <= '0;
      run_q <= 3'h0;
      level_q <= 1'b0;
      edge_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      run_q <= run_d;
      level_q <= level_d;
      edge_q <= edge_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_filter_tick;
    $changed(level_q) |-> $past(tick) && $past(run_q) == $past(glitch_width);
  endproperty
  a_filter_tick: assert property (p_filter_tick) else $error("Filtered level changed off a full run."); // see RULE3

endmodule

// File: logic/tct_timer_control.sv
// Control section of a six-channel timer: clock select, capture filters,
// DMA request routing, delayed ADC start trigger and user request strobes.
// Assumes channel status inputs are synchronous single-cycle pulses or levels on clk.
// Summary of operation
// RULE1 - One bit picks counter clock 0 or 1.
// RULE2 - Capture sampling rate divided by two^field.
// RULE3 - Edge accepted after width+1 agreeing samples.
// RULE4 - Enabled DMA line requests on each capture.
// RULE5 - Each DMA line routed to channel 0..5.
// RULE6 - ADC trigger only while its enable set.
// RULE7 - Source field picks channel for ADC trigger.
// RULE8 - Trigger ADC four-times-delay after period end.
// RULE9 - Software keeps delay below PWM period.
// RULE10 - Reload bit copies both match values to shadow.
// RULE11 - Reload while pending is dropped, fault flagged.
// RULE12 - PWM/one-shot reload waits period end or idle.
// RULE13 - Counter or channel reset completes pending reload.
// RULE14 - Software writes zero to reserved bits.
// RULE15 - Restart bit resets channel; same write aligns.
// RULE16 - Function codes 0,1,4,5,6,7; others reserved.
// RULE17 - Software restarts channels only while counting.
// RULE18 - Request bits are one-cycle strobes only.
`timescale 1ns/100ps
module tct_timer_control #(
  parameter int NUM_CH = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB register port
  input wire tct_pkg::tct_apb_req_s apb_req,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  // Channel side inputs
  input wire logic [5:0][2:0] chan_mode,
  input wire logic [5:0] period_end,
  input wire logic [5:0] chan_idle,
  input wire logic [5:0] capture_event,
  input wire logic counter_reset,
  input wire logic [5:0] trig_raw,
  // Channel side outputs
  output logic counter_clk_sel_q,
  output logic [5:0] trig_level_q,
  output logic [5:0] trig_edge_q,
  output logic [5:0] shadow_load_q,
  output logic [5:0] channel_restart_q,
  output logic [5:0] channel_fault_flag_q,
  // DMA controller and ADC
  output logic [1:0] dma_req_q,
  output logic adc_start_q
);

  // ==========================================================================
  // Helpers
  function automatic logic route_ok(input logic [2:0] sel);
    route_ok = (sel <= tct_pkg::LAST_CHANNEL);
  endfunction

  // Reloads in these functions wait for the period boundary.
  function automatic logic is_deferred(input logic [2:0] mode);
    is_deferred = (mode == tct_pkg::MODE_SHOT_PULSE) || (mode == tct_pkg::MODE_SHOT_EDGE) || // see RULE16
                  (mode == tct_pkg::MODE_PWM_EDGE) || (mode == tct_pkg::MODE_PWM_CENTER);
  endfunction

  // ==========================================================================
  // APB slave
  // Zero-wait access: pready rises in the first access cycle, read data is
  // captured in the setup cycle so that prdata also comes from a flop.
  logic setup, wr_en;
  logic wr_clk, wr_cap, wr_dma_en, wr_route, wr_adct, wr_dly, wr_user;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d, mapped;
  logic clk_sel_q, clk_sel_d;
  logic [2:0] divider_q, divider_d, glitch_q, glitch_d;
  logic [1:0] dma_en_q, dma_en_d;
  logic [2:0] route0_q, route0_d, route1_q, route1_d;
  logic adct_en_q, adct_en_d;
  logic [2:0] adct_sel_q, adct_sel_d;
  logic [31:0] dly_q, dly_d;

  always_comb begin
    setup = apb_req.psel && !apb_req.penable;
    wr_en = apb_req.psel && apb_req.penable && pready_q && apb_req.pwrite;
    wr_clk = wr_en && (apb_req.paddr == tct_pkg::OFF_CLK_CTRL);
    wr_cap = wr_en && (apb_req.paddr == tct_pkg::OFF_CAP_FILT);
    wr_dma_en = wr_en && (apb_req.paddr == tct_pkg::OFF_DMA_EN);
    wr_route = wr_en && (apb_req.paddr == tct_pkg::OFF_DMA_ROUTE);
    wr_adct = wr_en && (apb_req.paddr == tct_pkg::OFF_ADCT_CTRL);
    wr_dly = wr_en && (apb_req.paddr == tct_pkg::OFF_ADCT_DLY);
    wr_user = wr_en && (apb_req.paddr == tct_pkg::OFF_USER_REQ);
    mapped = 1'b1;
    prdata_d = 32'h0000_0000;
    unique case (apb_req.paddr)
      tct_pkg::OFF_CLK_CTRL: prdata_d[tct_pkg::CLK_SRC_BIT] = clk_sel_q;
      tct_pkg::OFF_CAP_FILT: begin
        prdata_d[tct_pkg::DIVIDER_LSB +: 3] = divider_q;
        prdata_d[tct_pkg::GLITCH_LSB +: 3] = glitch_q;
      end
      tct_pkg::OFF_DMA_EN: prdata_d[1:0] = dma_en_q;
      tct_pkg::OFF_DMA_ROUTE: begin
        prdata_d[tct_pkg::ROUTE1_LSB +: 3] = route1_q;
        prdata_d[tct_pkg::ROUTE0_LSB +: 3] = route0_q;
      end
      tct_pkg::OFF_ADCT_CTRL: begin
        prdata_d[tct_pkg::ADCT_EN_BIT] = adct_en_q;
        prdata_d[tct_pkg::ADCT_SEL_LSB +: 3] = adct_sel_q;
      end
      tct_pkg::OFF_ADCT_DLY: prdata_d = dly_q;
      // Request strobes are not stored, so this word reads as zero.  see RULE18
      tct_pkg::OFF_USER_REQ: prdata_d = 32'h0000_0000;
      default: mapped = 1'b0;
    endcase
    if (!setup) begin
      prdata_d = prdata_q;
    end
    pready_d = setup;
    pslverr_d = setup && !mapped;
    // Only defined field bits are stored; reserved bits read back as zero.
    clk_sel_d = wr_clk ? apb_req.pwdata[tct_pkg::CLK_SRC_BIT] : clk_sel_q;
    divider_d = wr_cap ? apb_req.pwdata[tct_pkg::DIVIDER_LSB +: 3] : divider_q;
    glitch_d = wr_cap ? apb_req.pwdata[tct_pkg::GLITCH_LSB +: 3] : glitch_q;
    dma_en_d = wr_dma_en ? apb_req.pwdata[1:0] : dma_en_q;
    route0_d = wr_route ? apb_req.pwdata[tct_pkg::ROUTE0_LSB +: 3] : route0_q;
    route1_d = wr_route ? apb_req.pwdata[tct_pkg::ROUTE1_LSB +: 3] : route1_q;
    adct_en_d = wr_adct ? apb_req.pwdata[tct_pkg::ADCT_EN_BIT] : adct_en_q;
    adct_sel_d = wr_adct ? apb_req.pwdata[tct_pkg::ADCT_SEL_LSB +: 3] : adct_sel_q;
    dly_d = wr_dly ? apb_req.pwdata : dly_q;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata_q <= tct_pkg::RST_REG;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      clk_sel_q <= 1'b0;
      divider_q <= 3'h0;
      glitch_q <= 3'h0;
      dma_en_q <= 2'h0;
      route0_q <= 3'h0;
      route1_q <= 3'h0;
      adct_en_q <= 1'b0;
      adct_sel_q <= 3'h0;
      dly_q <= tct_pkg::RST_REG;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      clk_sel_q <= clk_sel_d;
      divider_q <= divider_d;
      glitch_q <= glitch_d;
      dma_en_q <= dma_en_d;
      route0_q <= route0_d;
      route1_q <= route1_d;
      adct_en_q <= adct_en_d;
      adct_sel_q <= adct_sel_d;
      dly_q <= dly_d;
    end
  end

  // The counter clock mux itself sits in the counter; this drives its select.
  assign counter_clk_sel_q = clk_sel_q; // see RULE1

  // ==========================================================================
  // Capture filters, one per channel
  for (genvar i = 0; i < NUM_CH; i++) begin : g_filt
    tct_capture_filter i_tct_capture_filter (
      .clk(clk),
      .rstn(rstn),
      .divider(divider_q),
      .glitch_width(glitch_q),
      .trig_in(trig_raw[i]),
      .level_q(trig_level_q[i]),
      .edge_q(trig_edge_q[i])
    );
  end

  // ==========================================================================
  // DMA requests, reload and restart strobes
  logic [1:0] dma_req_d;
  logic [5:0] pend_q, pend_d, load_d, restart_d, fault_d, reload_req, chan_rst;
  logic [2:0] routes [2];

  always_comb begin
    routes[0] = route0_q;
    routes[1] = route1_q;
    for (int d = 0; d < tct_pkg::NUM_DMA; d++) begin
      // Reserved route codes never raise a request.  see RULE5
      dma_req_d[d] = dma_en_q[d] && route_ok(routes[d]) && capture_event[routes[d]] &&
                     (chan_mode[routes[d]] == tct_pkg::MODE_CAPTURE); // see RULE4
    end
    for (int i = 0; i < NUM_CH; i++) begin
      // Strobes live for the write cycle only.  see RULE18
      reload_req[i] = wr_user && apb_req.pwdata[tct_pkg::RELOAD_LSB + i];
      restart_d[i] = wr_user && apb_req.pwdata[tct_pkg::RESTART_LSB + i]; // see RULE15
      chan_rst[i] = restart_d[i] || counter_reset;
      pend_d[i] = pend_q[i];
      load_d[i] = 1'b0;
      fault_d[i] = 1'b0;
      if (pend_q[i] && (period_end[i] || chan_idle[i] || chan_rst[i])) begin
        load_d[i] = 1'b1; // see RULE13
        pend_d[i] = 1'b0;
      end
      if (reload_req[i]) begin
        if (pend_q[i]) begin
          fault_d[i] = 1'b1; // see RULE11
        end else if (!is_deferred(chan_mode[i]) || chan_idle[i] || chan_rst[i]) begin
          load_d[i] = 1'b1; // see RULE10
        end else begin
          pend_d[i] = 1'b1; // see RULE12
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dma_req_q <= 2'h0;
      pend_q <= 6'h00;
      shadow_load_q <= 6'h00;
      channel_restart_q <= 6'h00;
      channel_fault_flag_q <= 6'h00;
    end else begin
      dma_req_q <= dma_req_d;
      pend_q <= pend_d;
      shadow_load_q <= load_d;
      channel_restart_q <= restart_d;
      channel_fault_flag_q <= fault_d;
    end
  end

  // ==========================================================================
  // Delayed ADC start trigger
  // A new period end restarts the wait; a delay longer than the period never fires.
  tct_pkg::tct_adc_state_e adc_st_q, adc_st_d;
  logic [33:0] wait_q, wait_d;
  logic adc_start_d, adc_event;

  always_comb begin
    adc_event = adct_en_q && route_ok(adct_sel_q) && period_end[adct_sel_q]; // see RULE7
    adc_st_d = adc_st_q;
    wait_d = wait_q;
    adc_start_d = 1'b0;
    unique case (adc_st_q)
      tct_pkg::ADC_IDLE: ;
      tct_pkg::ADC_WAIT: begin
        if (wait_q == 34'h0) begin
          adc_start_d = 1'b1;
          adc_st_d = tct_pkg::ADC_IDLE;
        end else begin
          wait_d = wait_q - 34'h1;
        end
      end
    endcase
    if (adc_event) begin
      wait_d = {dly_q, 2'b00}; // see RULE8
      adc_st_d = tct_pkg::ADC_WAIT;
    end
    if (!adct_en_q) begin
      adc_st_d = tct_pkg::ADC_IDLE; // see RULE6
      adc_start_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      adc_st_q <= tct_pkg::ADC_IDLE;
      wait_q <= 34'h0;
      adc_start_q <= 1'b0;
    end else begin
      adc_st_q <= adc_st_d;
      wait_q <= wait_d;
      adc_start_q <= adc_start_d;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_clk_sel;
    wr_clk |=> ##1 counter_clk_sel_q == $past(apb_req.pwdata[0], 2);
  endproperty
  a_clk_sel: assert property (p_clk_sel) else $error("Clock select did not follow write."); // see RULE1

  property p_dma_req;
    dma_en_q[0] && route_ok(route0_q) && capture_event[route0_q] && chan_mode[route0_q] == tct_pkg::MODE_CAPTURE
      |=> dma_req_q[0];
  endproperty
  a_dma_req: assert property (p_dma_req) else $error("Capture did not raise DMA request."); // see RULE4

  property p_dma_route;
    dma_req_q[1] |-> $past(route_ok(route1_q) && dma_en_q[1] && capture_event[route1_q]);
  endproperty
  a_dma_route: assert property (p_dma_route) else $error("DMA request without routed capture."); // see RULE5

  property p_adc_en;
    adc_start_q |-> $past(adct_en_q) && $past(adc_st_q == tct_pkg::ADC_WAIT && wait_q == 34'h0);
  endproperty
  a_adc_en: assert property (p_adc_en) else $error("ADC start without enable or finished wait."); // see RULE6

  property p_adc_zero;
    adc_event && dly_q == 32'h0 && adct_en_q ##1 (adct_en_q && !adc_event) |=> adc_start_q;
  endproperty
  a_adc_zero: assert property (p_adc_zero) else $error("Zero delay trigger late."); // see RULE8

  property p_fault;
    reload_req[0] && pend_q[0] |=> channel_fault_flag_q[0];
  endproperty
  a_fault: assert property (p_fault) else $error("Second reload not flagged."); // see RULE11

  property p_reload_now;
    reload_req[1] && !pend_q[1] && (chan_mode[1] == tct_pkg::MODE_NONE || chan_mode[1] == tct_pkg::MODE_CAPTURE)
      |=> shadow_load_q[1] && !pend_q[1];
  endproperty
  a_reload_now: assert property (p_reload_now) else $error("Immediate reload missed."); // see RULE12

  property p_reset_done;
    pend_q[2] && counter_reset |=> shadow_load_q[2] && !pend_q[2];
  endproperty
  a_reset_done: assert property (p_reset_done) else $error("Reset did not finish reload."); // see RULE13

  property p_strobe;
    channel_restart_q != 6'h00 |-> $past(wr_user) ##1 (channel_restart_q == 6'h00 || $past(wr_user));
  endproperty
  a_strobe: assert property (p_strobe) else $error("Restart strobe outlived its write."); // see RULE18

endmodule

// File: tb/tct_far_side.sv
// DMA controller and ADC start input, reduced to counters of what the timer asks of them.
// Assumes both request lines are single-cycle pulses synchronous to clk.
`timescale 1ns/100ps
module tct_far_side (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Requests from the timer
  input wire logic [1:0] dma_req,
  input wire logic adc_start,
  // Observations
  output logic [31:0] cyc,
  output logic [31:0] adc_cyc,
  output logic [31:0] n_adc,
  output logic [31:0] n_dma0,
  output logic [31:0] n_dma1
);
  // ====================
  // Request counters
  // The cycle stamp lets the bench measure the trigger delay exactly.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cyc <= 32'h0;
      adc_cyc <= 32'h0;
      n_adc <= 32'h0;
      n_dma0 <= 32'h0;
      n_dma1 <= 32'h0;
    end else begin
      cyc <= cyc + 32'h1;
      if (adc_start) begin
        n_adc <= n_adc + 32'h1;
        adc_cyc <= cyc;
      end
      if (dma_req[0]) n_dma0 <= n_dma0 + 32'h1;
      if (dma_req[1]) n_dma1 <= n_dma1 + 32'h1;
    end
  end
endmodule

// File: tb/tct_timer_control_tb_top.sv
// Self-checking bench of the timer control block: registers, filter, DMA, ADC trigger, user requests.
// Assumes the far-side model tct_far_side and the design package tct_pkg.
`timescale 1ns/100ps
module tct_timer_control_tb_top;
  // ====================
  // Signals
  logic clk;
  logic rstn;
  tct_pkg::tct_apb_req_s req;
  logic [31:0] prdata;
  logic pready;
  logic perr;
  logic [5:0][2:0] chan_mode;
  logic [5:0] period_end;
  logic [5:0] chan_idle;
  logic [5:0] cap_ev;
  logic counter_reset;
  logic [5:0] trig_raw;
  logic clk_sel;
  logic [5:0] trig_level;
  logic [5:0] trig_edge;
  logic [5:0] load;
  logic [5:0] restart;
  logic [5:0] fault;
  logic [1:0] dma_req;
  logic adc_start;
  logic [31:0] cyc;
  logic [31:0] adc_cyc;
  logic [31:0] n_adc;
  logic [31:0] n_dma0;
  logic [31:0] n_dma1;
  int n_mismatch;
  int checked;
  int n_edge;
  int n_rst_cyc;
  int n_load[6];
  int n_rst[6];
  int n_fault[6];

  tct_timer_control #(.NUM_CH(6)) i_tct_timer_control (.clk(clk), .rstn(rstn), .apb_req(req), .prdata_q(prdata),
    .pready_q(pready), .pslverr_q(perr), .chan_mode(chan_mode), .period_end(period_end), .chan_idle(chan_idle),
    .capture_event(cap_ev), .counter_reset(counter_reset), .trig_raw(trig_raw), .counter_clk_sel_q(clk_sel),
    .trig_level_q(trig_level), .trig_edge_q(trig_edge), .shadow_load_q(load), .channel_restart_q(restart),
    .channel_fault_flag_q(fault), .dma_req_q(dma_req), .adc_start_q(adc_start));
  tct_far_side i_tct_far_side (.clk(clk), .rstn(rstn), .dma_req(dma_req), .adc_start(adc_start), .cyc(cyc),
    .adc_cyc(adc_cyc), .n_adc(n_adc), .n_dma0(n_dma0), .n_dma1(n_dma1));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ====================
  // Pulse counters
  // Strobes are counted rather than timed; exact cycles are guarded inside the design.
  always @(posedge clk) begin
    if (rstn === 1'b1) begin
      if (trig_edge[0] === 1'b1) n_edge++;
      if (restart !== 6'h00) n_rst_cyc++;
      for (int i = 0; i < 6; i++) begin
        if (load[i] === 1'b1) n_load[i]++;
        if (restart[i] === 1'b1) n_rst[i]++;
        if (fault[i] === 1'b1) n_fault[i]++;
      end
    end
  end

  // ====================
  // Helpers
  task automatic summarize();
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Reserved bits are always written as zero.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    int k;
    @(negedge clk);
    req = '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(negedge clk);
    req.penable = 1'b1;
    k = 0;
    while (pready !== 1'b1 && k < 8) begin
      @(negedge clk);
      k++;
    end
    if (pready !== 1'b1) begin
      n_mismatch++;
      summarize();
    end
    @(posedge clk);
    rd = prdata;
    er = perr;
    @(negedge clk);
    req = '0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] exp, input logic xer);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0, rd, er);
    chk(n, exp, rd);
    chk("pslverr", {31'h0, xer}, {31'h0, er});
  endtask

  // ====================
  // Scenarios
  task automatic t_regs();
    logic [11:0] offs [7];
    logic [31:0] vals [7];
    offs = '{12'h080, 12'h090, 12'h0a0, 12'h0a4, 12'h0d0, 12'h0d8, 12'h0f0};
    vals = '{32'h1, 32'h52, 32'h3, 32'h53, 32'h105, 32'hdeadbeef, 32'h0};
    for (int i = 0; i < 7; i++) rd_chk("reset", offs[i], 32'h0, 1'b0);
    rd_chk("unmapped", 12'h0fc, 32'h0, 1'b1);
    for (int i = 0; i < 7; i++) wr(offs[i], vals[i]);
    for (int i = 0; i < 6; i++) rd_chk("readback", offs[i], vals[i], 1'b0);
    chk("clk_sel", 32'h1, clk_sel);
    wr(12'h080, 32'h0);
    idle(2);
    chk("clk_sel", 32'h0, clk_sel);
  endtask

  task automatic t_filter();
    int e0;
    wr(12'h090, 32'h2);
    idle(4);
    e0 = n_edge;
    trig_raw[0] = 1'b1;
    idle(2);
    trig_raw[0] = 1'b0;
    idle(6);
    chk("glitch", e0, n_edge);
    trig_raw[0] = 1'b1;
    idle(3);
    trig_raw[0] = 1'b0;
    idle(10);
    chk("pulse", e0 + 2, n_edge);
    wr(12'h090, 32'h21);
    idle(8);
    trig_raw[0] = 1'b1;
    idle(4);
    trig_raw[0] = 1'b0;
    idle(12);
    chk("divided", e0 + 2, n_edge);
    trig_raw[0] = 1'b1;
    idle(16);
    chk("divided", e0 + 3, n_edge);
    chk("level", 32'h1, trig_level[0]);
  endtask

  task automatic cap(input logic [5:0] m);
    cap_ev = m;
    @(negedge clk);
    cap_ev = 6'h00;
    idle(3);
  endtask

  task automatic t_dma();
    logic [31:0] d0;
    logic [31:0] d1;
    d0 = n_dma0;
    d1 = n_dma1;
    wr(12'h0a4, 32'h53);
    wr(12'h0a0, 32'h3);
    chan_mode[3] = tct_pkg::MODE_CAPTURE;
    cap(6'h28);
    chk("dma0", d0 + 1, n_dma0);
    chk("dma1", d1, n_dma1);
    chan_mode[5] = tct_pkg::MODE_CAPTURE;
    wr(12'h0a0, 32'h2);
    cap(6'h28);
    chk("dma0", d0 + 1, n_dma0);
    chk("dma1", d1 + 1, n_dma1);
    wr(12'h0a4, 32'h36);
    wr(12'h0a0, 32'h3);
    cap(6'h3f);
    chk("dma0", d0 + 1, n_dma0);
    chk("dma1", d1 + 2, n_dma1);
  endtask

  task automatic pe(input logic [5:0] m, output logic [31:0] t0);
    period_end = m;
    @(posedge clk);
    t0 = cyc;
    @(negedge clk);
    period_end = 6'h00;
  endtask

  task automatic t_adc();
    logic [31:0] t0;
    logic [31:0] a0;
    a0 = n_adc;
    chan_mode = {6{tct_pkg::MODE_PWM_EDGE}};
    wr(12'h0d8, 32'h3);
    wr(12'h0d0, 32'h102);
    pe(6'h04, t0);
    idle(16);
    chk("adc_n", a0 + 1, n_adc);
    chk("adc_at", t0 + 14, adc_cyc);
    pe(6'h3b, t0);
    idle(16);
    chk("adc_mux", a0 + 1, n_adc);
    wr(12'h0d8, 32'h0);
    pe(6'h04, t0);
    idle(4);
    chk("adc_at", t0 + 2, adc_cyc);
    wr(12'h0d0, 32'h106);
    pe(6'h3f, t0);
    idle(8);
    chk("adc_rsvd", a0 + 2, n_adc);
    wr(12'h0d8, 32'h5);
    wr(12'h0d0, 32'h102);
    pe(6'h04, t0);
    idle(2);
    wr(12'h0d0, 32'h2);
    idle(30);
    chk("adc_off", a0 + 2, n_adc);
  endtask

  task automatic t_reload();
    int r0;
    chan_mode = {tct_pkg::MODE_PWM_EDGE, tct_pkg::MODE_PWM_EDGE, tct_pkg::MODE_PWM_CENTER,
                 tct_pkg::MODE_SHOT_PULSE, tct_pkg::MODE_NONE, tct_pkg::MODE_PWM_EDGE};
    wr(12'h0f0, 32'h0002_0000);
    idle(3);
    chk("load1", 32'h1, n_load[1]);
    wr(12'h0f0, 32'h0001_0000);
    idle(3);
    chk("load0", 32'h0, n_load[0]);
    wr(12'h0f0, 32'h0001_0000);
    idle(3);
    chk("fault0", 32'h1, n_fault[0]);
    period_end = 6'h01;
    @(negedge clk);
    period_end = 6'h00;
    idle(3);
    chk("load0", 32'h1, n_load[0]);
    wr(12'h0f0, 32'h0004_0000);
    counter_reset = 1'b1;
    @(negedge clk);
    counter_reset = 1'b0;
    idle(3);
    chk("load2", 32'h1, n_load[2]);
    wr(12'h0f0, 32'h0008_0000);
    chan_idle = 6'h08;
    idle(3);
    chan_idle = 6'h00;
    chk("load3", 32'h1, n_load[3]);
    r0 = n_rst_cyc;
    wr(12'h0f0, 32'h0010_1000);
    idle(3);
    chk("load4", 32'h1, n_load[4]);
    wr(12'h0f0, 32'h0000_2300);
    idle(6);
    chk("rst0", 32'h1, n_rst[0]);
    chk("rst5", 32'h1, n_rst[5]);
    chk("rst4", 32'h1, n_rst[4]);
    chk("aligned", r0 + 2, n_rst_cyc);
    rd_chk("user_req", 12'h0f0, 32'h0, 1'b0);
  endtask

  // ====================
  // Main sequence
  initial begin
    rstn = 1'b0;
    req = '0;
    chan_mode = '0;
    period_end = 6'h00;
    chan_idle = 6'h00;
    cap_ev = 6'h00;
    counter_reset = 1'b0;
    trig_raw = 6'h00;
    n_mismatch = 0;
    checked = 0;
    n_edge = 0;
    n_rst_cyc = 0;
    for (int i = 0; i < 6; i++) begin
      n_load[i] = 0;
      n_rst[i] = 0;
      n_fault[i] = 0;
    end
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    t_regs();
    t_filter();
    t_dma();
    t_adc();
    t_reload();
    summarize();
  end
endmodule
